// ---- verilog/gss_pkg.sv ----
// Shared constants for the gain and system status register block
package gss_pkg;
  localparam logic [4:0] GSS_ADDR_GAIN_STATUS = 5'h0A;
  localparam int GSS_NVM_ADDR_BIT = 4;
  localparam int GSS_GAIN0_BIT = 8;
  localparam int GSS_POR_BIT = 7;
  localparam int GSS_NVM_BIT = 6;
  localparam int GSS_REG_WIDTH = 16;
  localparam int GSS_REF_SEL_WIDTH = 2;
  localparam logic [1:0] GSS_REF_SEL_VDD = 2'h0;
  localparam logic GSS_POR_RESET = 1'b1;
  localparam logic GSS_GAIN_RESET = 1'b0;
  localparam logic [15:0] GSS_DATA_RESET = 16'h0000;
endpackage

// ---- verilog/gss_stat_if.sv ----
// Status flags passed between the register front end and the status keeper
`timescale 1ns/1ps
interface gss_stat_if;
  logic por_flag;
  logic nvm_flag;
  logic clr_por;
  modport regs (input por_flag, input nvm_flag, output clr_por);
  modport stat (output por_flag, output nvm_flag, input clr_por);
endinterface

// ---- verilog/gss_status.sv ----
// Keeps the reset-event flag and the nonvolatile-access flag
`timescale 1ns/1ps
module gss_status import gss_pkg::*; #(
  parameter bit HAS_NVM = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic brownout_event_in,
  input wire logic nvm_load_busy_in,
  input wire logic nvm_write_busy_in,
  gss_stat_if.stat bus
);
  logic event_meta;
  logic event_sync;
  logic next_por;
  logic next_nvm;

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out arrives from the analogue side, so it is synchronised first
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_meta <= 1'b0;
      event_sync <= 1'b0;
    end else if (ce_in) begin
      event_meta <= brownout_event_in;
      event_sync <= event_meta;
    end
  end

  // An event in the clearing cycle wins, so a clear never drops a reset event
  assign next_por = event_sync ? 1'b1 : (bus.clr_por ? 1'b0 : bus.por_flag);

  generate
    if (HAS_NVM) begin : g_nvm
      assign next_nvm = nvm_load_busy_in | nvm_write_busy_in;
    end else begin : g_vol
      assign next_nvm = 1'b0;
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus.por_flag <= GSS_POR_RESET;
      bus.nvm_flag <= 1'b0;
    end else if (ce_in) begin
      bus.por_flag <= next_por;
      bus.nvm_flag <= next_nvm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_por_event_set: assert property (ce_in && event_sync |=> bus.por_flag)
    else $error("reset-event flag not set by event");
  a_por_read_clear: assert property (ce_in && bus.clr_por && !event_sync |=> !bus.por_flag)
    else $error("reset-event flag not cleared by read");
  a_por_holds_idle: assert property (ce_in && !bus.clr_por && !event_sync |=> $stable(bus.por_flag))
    else $error("reset-event flag changed without cause");
  a_nvm_flag_track: assert property (ce_in |=> bus.nvm_flag == (HAS_NVM && ($past(nvm_load_busy_in)
    || $past(nvm_write_busy_in))))
    else $error("nvm access flag does not follow busy");
endmodule

// ---- verilog/gss_regs.sv ----
// Gain select and system status register with command front end
// Operation
// - Unimplemented bits, above the gain field and bits 5-0, read as zero.
// - On dual parts bit 9 selects gain for channel 1: one doubles.
// - Bit 8 selects gain for channel 0 on all parts: one doubles.
// - Supply-rail reference code forces that channel to unity gain.
// - Bit 7 is set by any reset event and powers up as one.
// - A read of this register clears bit 7 until the next event.
// - Bit 6 reads one during power-up load or nonvolatile write.
// - While bit 6 is one, only volatile-memory commands are accepted.
// - Volatile-only builds always read zero in bit 6.
// - Each channel has a two-bit reference field; code 00 is supply rail.
`timescale 1ns/1ps
module gss_regs import gss_pkg::*; #(
  parameter int NUM_CHAN = 2,
  parameter bit HAS_NVM = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_wr_in,
  input wire logic [4:0] cmd_addr_in,
  input wire logic [GSS_REG_WIDTH-1:0] cmd_wdata_in,
  input wire logic [GSS_REF_SEL_WIDTH*NUM_CHAN-1:0] ref_source_sel_in,
  input wire logic nvm_load_valid_in,
  input wire logic [NUM_CHAN-1:0] nvm_load_gain_in,
  input wire logic nvm_load_busy_in,
  input wire logic nvm_write_busy_in,
  input wire logic brownout_event_in,
  output logic cmd_ack_out,
  output logic cmd_refuse_out,
  output logic rd_valid_out,
  output logic [GSS_REG_WIDTH-1:0] rd_data_out,
  output logic [NUM_CHAN-1:0] gain_applied_out
);
  gss_stat_if stat_bus ();

  logic [NUM_CHAN-1:0] chan_gain_sel;
  logic [NUM_CHAN-1:0] next_gain_sel;
  logic [NUM_CHAN-1:0] next_gain_applied;
  logic [GSS_REG_WIDTH-1:0] read_word;
  logic [GSS_REG_WIDTH-1:0] gain_field;
  logic cmd_is_nvm;
  logic cmd_hit;
  logic cmd_refused;
  logic cmd_taken;
  logic reg_write;
  logic reg_read;

  gss_status #(.HAS_NVM(HAS_NVM)) u_status (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .brownout_event_in(brownout_event_in),
    .nvm_load_busy_in(nvm_load_busy_in),
    .nvm_write_busy_in(nvm_write_busy_in),
    .bus(stat_bus.stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign cmd_is_nvm = cmd_addr_in[GSS_NVM_ADDR_BIT];
  assign cmd_hit = cmd_addr_in == GSS_ADDR_GAIN_STATUS;
  // Nonvolatile addresses are turned away while the memory is busy
  assign cmd_refused = cmd_valid_in & cmd_is_nvm & stat_bus.nvm_flag;
  assign cmd_taken = cmd_valid_in & ~cmd_refused;
  assign reg_write = cmd_taken & cmd_wr_in & cmd_hit;
  assign reg_read = cmd_taken & ~cmd_wr_in & cmd_hit;
  // Only a read clears the reset-event flag; writes never touch it
  assign stat_bus.clr_por = reg_read & ce_in;

  // Read image: gain field, two flags, every other bit zero
  assign gain_field = GSS_REG_WIDTH'(chan_gain_sel) << GSS_GAIN0_BIT;
  assign read_word = gain_field
    | (GSS_REG_WIDTH'(stat_bus.por_flag) << GSS_POR_BIT)
    | (GSS_REG_WIDTH'(stat_bus.nvm_flag) << GSS_NVM_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel gain select and effective gain
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic [GSS_REF_SEL_WIDTH-1:0] ref_sel;
      assign ref_sel = ref_source_sel_in[ch*GSS_REF_SEL_WIDTH +: GSS_REF_SEL_WIDTH];
      // Host write lands after a same-cycle power-up load
      assign next_gain_sel[ch] = reg_write ? cmd_wdata_in[GSS_GAIN0_BIT+ch]
        : (nvm_load_valid_in ? nvm_load_gain_in[ch] : chan_gain_sel[ch]);
      // Doubling is meaningless on the supply rail, so it is masked there
      assign next_gain_applied[ch] = chan_gain_sel[ch] & (ref_sel != GSS_REF_SEL_VDD);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_gain_sel <= {NUM_CHAN{GSS_GAIN_RESET}};
      gain_applied_out <= {NUM_CHAN{GSS_GAIN_RESET}};
    end else if (ce_in) begin
      chan_gain_sel <= next_gain_sel;
      gain_applied_out <= next_gain_applied;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_ack_out <= 1'b0;
      cmd_refuse_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= GSS_DATA_RESET;
    end else if (ce_in) begin
      cmd_ack_out <= cmd_taken;
      cmd_refuse_out <= cmd_refused;
      rd_valid_out <= reg_read;
      if (reg_read) begin
        rd_data_out <= read_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  localparam logic [GSS_REG_WIDTH-1:0] IMPL_MASK = (GSS_REG_WIDTH'((1 << NUM_CHAN) - 1) << GSS_GAIN0_BIT)
    | (GSS_REG_WIDTH'(1) << GSS_POR_BIT) | (GSS_REG_WIDTH'(1) << GSS_NVM_BIT);

  sequence s_read_hit;
    ce_in && cmd_valid_in && !cmd_wr_in && cmd_addr_in == GSS_ADDR_GAIN_STATUS;
  endsequence
  sequence s_answer_then_cleared;
    rd_valid_out && rd_data_out[GSS_POR_BIT] ##1 !ce_in || !stat_bus.por_flag || $past(u_status.event_sync);
  endsequence

  a_zero_unimpl: assert property (rd_valid_out |-> (rd_data_out & ~IMPL_MASK) == '0)
    else $error("unimplemented bits read nonzero");
  a_por_read_answer: assert property ((s_read_hit and stat_bus.por_flag) |=> s_answer_then_cleared)
    else $error("reset-event flag not reported then cleared");
  a_refuse_nvm_cmd: assert property (ce_in && cmd_valid_in && cmd_is_nvm && stat_bus.nvm_flag
    |=> cmd_refuse_out && !cmd_ack_out)
    else $error("nonvolatile command taken while busy");
  a_vol_cmd_taken: assert property (ce_in && cmd_valid_in && !cmd_is_nvm |=> cmd_ack_out && !cmd_refuse_out)
    else $error("volatile command not taken");
  a_gain_write: assert property (ce_in && reg_write |=> chan_gain_sel
    == $past(cmd_wdata_in[GSS_GAIN0_BIT +: NUM_CHAN]))
    else $error("gain select not written");
  a_unity_on_vdd: assert property (ce_in && ref_source_sel_in[1:0] == GSS_REF_SEL_VDD
    |=> !gain_applied_out[0])
    else $error("gain doubled on supply reference");
  a_double_gain: assert property (ce_in && chan_gain_sel[0] && ref_source_sel_in[1:0] != GSS_REF_SEL_VDD
    |=> gain_applied_out[0])
    else $error("gain not doubled when selected");
  a_write_keeps_flag: assert property (ce_in && reg_write && stat_bus.por_flag |=> stat_bus.por_flag)
    else $error("write cleared reset-event flag");
  a_nvm_bit_reads: assert property (s_read_hit |=> rd_data_out[GSS_NVM_BIT] == (HAS_NVM && $past(stat_bus.nvm_flag)))
    else $error("nvm access bit read wrong");
endmodule

// ---- sim/gss_host.sv ----
// Host-side command issuer standing in for the serial bus controller
`timescale 1ns/1ps
module gss_host (
  input wire logic mclk_in,
  input wire logic ack_in,
  input wire logic refuse_in,
  input wire logic rd_valid_in,
  input wire logic [15:0] rd_data_in,
  output logic cmd_valid_out = 1'b0,
  output logic cmd_wr_out = 1'b0,
  output logic [4:0] cmd_addr_out = 5'h00,
  output logic [15:0] cmd_wdata_out = 16'h0000
);
  // Nonvolatile addresses are only sent while busy when a test asks for a refusal
  task automatic cmd(input logic wr, input logic [4:0] addr, input logic [15:0] data, output logic ack,
                     output logic refused, output logic rv, output logic [15:0] rdata);
    int n;
    n = 0;
    @(posedge mclk_in);
    cmd_valid_out <= 1'b1;
    cmd_wr_out <= wr;
    cmd_addr_out <= addr;
    cmd_wdata_out <= data;
    @(posedge mclk_in);
    cmd_valid_out <= 1'b0;
    // Released lines show the inverse so stale values never pass for live ones
    cmd_wr_out <= ~wr;
    cmd_addr_out <= ~addr;
    cmd_wdata_out <= ~data;
    #1;
    while (n < 4 && ack_in !== 1'b1 && refuse_in !== 1'b1) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    ack = ack_in;
    refused = refuse_in;
    rv = rd_valid_in;
    rdata = rd_data_in;
  endtask
endmodule

// ---- sim/test_gain_and_system_status_register.sv ----
// Testbench for the gain and system status register block
`timescale 1ns/1ps
module test_gain_and_system_status_register;
  import gss_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce = 1'b1;
  logic [3:0] ref_sel = 4'hF;
  logic ld_v = 1'b0;
  logic [1:0] ld_g = 2'h0;
  logic ld_busy = 1'b0;
  logic wr_busy = 1'b0;
  logic bo = 1'b0;
  logic valid, wr, ack_w, ref_w, rv_w, a, r, v;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, q;
  logic [1:0] gain;
  logic vol_ack, vol_ref, vol_rv, vol_gain;
  logic [15:0] vol_rdata;
  int miscompares = 0;
  int checked = 0;
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  gss_regs #(.NUM_CHAN(2), .HAS_NVM(1'b1)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .cmd_valid_in(valid), .cmd_wr_in(wr), .cmd_addr_in(addr), .cmd_wdata_in(wdata), .ref_source_sel_in(ref_sel),
    .nvm_load_valid_in(ld_v), .nvm_load_gain_in(ld_g), .nvm_load_busy_in(ld_busy), .nvm_write_busy_in(wr_busy),
    .brownout_event_in(bo), .cmd_ack_out(ack_w), .cmd_refuse_out(ref_w), .rd_valid_out(rv_w),
    .rd_data_out(rdata), .gain_applied_out(gain));
  // Single-channel volatile-only build sees the same commands
  gss_regs #(.NUM_CHAN(1), .HAS_NVM(1'b0)) u_vol (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce),
    .cmd_valid_in(valid), .cmd_wr_in(wr), .cmd_addr_in(addr), .cmd_wdata_in(wdata), .ref_source_sel_in(ref_sel[1:0]),
    .nvm_load_valid_in(ld_v), .nvm_load_gain_in(ld_g[0]), .nvm_load_busy_in(ld_busy), .nvm_write_busy_in(wr_busy),
    .brownout_event_in(bo), .cmd_ack_out(vol_ack), .cmd_refuse_out(vol_ref), .rd_valid_out(vol_rv),
    .rd_data_out(vol_rdata), .gain_applied_out(vol_gain));
  gss_host u_host (.mclk_in(mclk_in), .ack_in(ack_w), .refuse_in(ref_w), .rd_valid_in(rv_w),
    .rd_data_in(rdata), .cmd_valid_out(valid), .cmd_wr_out(wr), .cmd_addr_out(addr), .cmd_wdata_out(wdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic rd(input logic [15:0] exp);
    u_host.cmd(1'b0, GSS_ADDR_GAIN_STATUS, 16'h0000, a, r, v, q);
    check({14'h0, a, v}, 16'h0003);
    check(q, exp);
  endtask
  task automatic wr_reg(input logic [15:0] d);
    u_host.cmd(1'b1, GSS_ADDR_GAIN_STATUS, d, a, r, v, q);
    check({15'h0, a}, 16'h0001);
  endtask
  initial begin
    repeat (4000) @(posedge mclk_in);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(16'h0080);
    rd(16'h0000);
    wr_reg(16'hFFFF);
    rd(16'h0300);
    check(vol_rdata, 16'h0100);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      ref_sel <= {i[1:0], i[1:0]};
      repeat (3) @(posedge mclk_in);
      #1;
      check({14'h0, gain}, (i == 0) ? 16'h0000 : 16'h0003);
    end
    wr_reg(16'h0100);
    rd(16'h0100);
    wr_reg(16'h0200);
    rd(16'h0200);
    @(posedge mclk_in);
    wr_busy <= 1'b1;
    rd(16'h0240);
    check(vol_rdata, 16'h0000);
    u_host.cmd(1'b1, 5'h1A, 16'h0000, a, r, v, q);
    check({14'h0, a, r}, 16'h0001);
    @(posedge mclk_in);
    wr_busy <= 1'b0;
    ld_busy <= 1'b1;
    rd(16'h0240);
    @(posedge mclk_in);
    ld_busy <= 1'b0;
    ld_v <= 1'b1;
    ld_g <= 2'h1;
    @(posedge mclk_in);
    ld_v <= 1'b0;
    rd(16'h0100);
    @(posedge mclk_in);
    bo <= 1'b1;
    @(posedge mclk_in);
    bo <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rd(16'h0180);
    rd(16'h0100);
    // Clock enable low freezes the block: a write is neither taken nor applied
    @(posedge mclk_in);
    ce <= 1'b0;
    u_host.cmd(1'b1, GSS_ADDR_GAIN_STATUS, 16'h0300, a, r, v, q);
    check({14'h0, a, r}, 16'h0000);
    @(posedge mclk_in);
    ce <= 1'b1;
    rd(16'h0100);
    close_out();
  end
endmodule
